// ===== design/vsm_pkg.sv
`default_nettype none
package vsm_pkg;
  // Register byte offsets
  localparam logic [7:0] VSM_CMD_OFS = 8'h00;
  localparam logic [7:0] VSM_CTRL_OFS = 8'h04;
  localparam logic [7:0] VSM_VOLUME_OFS = 8'h08;
  localparam logic [7:0] VSM_TXGAIN_OFS = 8'h0c;
  localparam logic [7:0] VSM_VOXLVL_OFS = 8'h10;
  localparam logic [7:0] VSM_SQUELCH_OFS = 8'h14;
  localparam logic [7:0] VSM_STATUS_OFS = 8'h18;

  // Command codes written to the command register
  localparam logic [1:0] VSM_CMD_DATA = 2'h1;
  localparam logic [1:0] VSM_CMD_VOICE_RX = 2'h2;
  localparam logic [1:0] VSM_CMD_VOICE_TX = 2'h3;

  // Field positions
  localparam int VSM_CTRL_VOX_BIT = 0;
  localparam int VSM_ST_TXKEY_BIT = 2;
  localparam int VSM_ST_SQOPEN_BIT = 3;
  localparam int VSM_ST_VOXHOLD_BIT = 4;

  // Reset values and the volume limit
  localparam logic [3:0] VSM_VOLUME_RST = 4'h6;
  localparam logic [7:0] VSM_TXGAIN_RST = 8'h80;
  localparam logic [15:0] VSM_VOXLVL_RST = 16'h0000;
  localparam logic [15:0] VSM_SQUELCH_RST = 16'h0000;
  localparam logic [3:0] VSM_VOLUME_MAX = 4'hf;

  // Timing
  localparam int VSM_CLK_HZ = 100_000_000;
  localparam int VSM_VOX_HOLD_S = 2;
  localparam int VSM_VOX_HOLD_CYCLES = VSM_VOX_HOLD_S * VSM_CLK_HZ;
  localparam int VSM_ENV_DECAY_SHIFT = 4;

  // AXI4-Lite responses
  localparam logic [1:0] VSM_RESP_OKAY = 2'h0;
  localparam logic [1:0] VSM_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    VSM_MODE_DATA,
    VSM_MODE_VOICE_RX,
    VSM_MODE_VOICE_TX
  } vsm_mode_e;

  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } vsm_axi_req_s;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } vsm_axi_rsp_s;
endpackage
`default_nettype wire

// ===== design/vsm_voice_ctrl.sv
// Our own choices: the AXI4-Lite register port and the address map.
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - Transmit and receive audio are never active together; half duplex.
// - Voice-transmit command enters transmit mode, lights LED, routes mic.
// - In voice-receive mode with keying source 0, both talk lines low keys the transmitter while held.
// - In voice-receive mode with keying source 0, both talk lines high gives receive with transmitter unkeyed.
// - Line states 01 and 10 step headphone volume up or down 1 dB.
// - Keying source 0 is push-to-talk, 1 is voice activated.
// - Voice activation keys when speech level reaches the trigger threshold.
// - Voice-activated keying holds the transmitter for 2 seconds.
// - Voice-receive command leaves data mode and presents demodulated audio.
// - Receive audio is scaled by the headphone volume setting.
// - Squelch mutes receive audio while level is below threshold.
// - Squelch threshold zero disables squelch; audio presented whenever unkeyed in voice mode.
// - Microphone gain, hence transmit power, follows the gain setting.
// - Data-mode command leaves voice operation for data modem mode.
module vsm_voice_ctrl #(
  parameter int VOX_HOLD_CYCLES = vsm_pkg::VSM_VOX_HOLD_CYCLES
) (
  input wire logic CLOCK,
  input wire logic RST_B,
  input wire vsm_pkg::vsm_axi_req_s AXI_REQ,
  output var vsm_pkg::vsm_axi_rsp_s AXI_RSP,
  input wire logic TALK_LINE_A,
  input wire logic TALK_LINE_B,
  input wire logic [15:0] MIC_SAMPLE,
  input wire logic [15:0] RX_SAMPLE,
  output logic [15:0] MOD_SAMPLE,
  output logic [15:0] AUDIO_OUT,
  output logic TX_KEY,
  output logic TX_LED,
  output logic VOICE_ACTIVE
);
  import vsm_pkg::*;

  vsm_axi_rsp_s rsp_reg;
  logic aw_held_reg;
  logic [7:0] aw_addr_reg;
  logic w_held_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic wr_fire;
  logic wr_hit;
  vsm_mode_e mode_reg;
  logic vox_mode_reg;
  logic [3:0] atten_reg;
  logic [7:0] txgain_reg;
  logic [15:0] voxlvl_reg;
  logic [15:0] squelch_reg;
  logic [1:0] lines_prev_reg;
  logic [31:0] vox_cnt_reg;
  logic [15:0] env_reg;
  logic [15:0] env_next;
  logic [15:0] mic_abs;
  logic [15:0] rx_abs;
  logic [1:0] lines;
  logic click_up;
  logic click_down;
  logic vox_trig;
  logic key_next;
  logic sq_open;
  logic [8:0] vol_gain;
  logic signed [25:0] rx_prod;
  logic signed [24:0] mic_prod;
  logic [31:0] rd_data;
  logic rd_hit;
  logic [31:0] wr_old;
  logic [31:0] wr_word;

  // Merge a write into a register under byte strobes
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] data,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // Magnitude of a signed sample; -32768 still fits unsigned
  function automatic logic [15:0] mag(input logic [15:0] x);
    return x[15] ? 16'(-x) : x;
  endfunction

  // Q8 gain per 1 dB of attenuation; index 0 is unity
  function automatic logic [8:0] db_gain(input logic [3:0] a);
    logic [8:0] g;
    case (a)
      4'h0: g = 9'h100;
      4'h1: g = 9'h0e4;
      4'h2: g = 9'h0cb;
      4'h3: g = 9'h0b5;
      4'h4: g = 9'h0a2;
      4'h5: g = 9'h090;
      4'h6: g = 9'h080;
      4'h7: g = 9'h072;
      4'h8: g = 9'h066;
      4'h9: g = 9'h05b;
      4'ha: g = 9'h051;
      4'hb: g = 9'h048;
      4'hc: g = 9'h040;
      4'hd: g = 9'h039;
      4'he: g = 9'h033;
      default: g = 9'h02e;
    endcase
    return g;
  endfunction

  // Write address and data may arrive in either order
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
    end else if (wr_fire) begin
      aw_held_reg <= 1'b0;
    end else if (AXI_REQ.awvalid && rsp_reg.awready) begin
      aw_held_reg <= 1'b1;
      aw_addr_reg <= AXI_REQ.awaddr;
    end
  end

  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      w_held_reg <= 1'b0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
    end else if (wr_fire) begin
      w_held_reg <= 1'b0;
    end else if (AXI_REQ.wvalid && rsp_reg.wready) begin
      w_held_reg <= 1'b1;
      w_data_reg <= AXI_REQ.wdata;
      w_strb_reg <= AXI_REQ.wstrb;
    end
  end

  // One write at a time: commit once both halves are held
  assign wr_fire = aw_held_reg && w_held_reg && !rsp_reg.bvalid;
  assign wr_hit = (aw_addr_reg == VSM_CMD_OFS) ||
                  (aw_addr_reg == VSM_CTRL_OFS) ||
                  (aw_addr_reg == VSM_VOLUME_OFS) ||
                  (aw_addr_reg == VSM_TXGAIN_OFS) ||
                  (aw_addr_reg == VSM_VOXLVL_OFS) ||
                  (aw_addr_reg == VSM_SQUELCH_OFS);

  // Old value of the addressed register, for byte-strobe merging
  always_comb begin
    wr_old = 32'h0000_0000;
    if (aw_addr_reg == VSM_CTRL_OFS) begin
      wr_old[VSM_CTRL_VOX_BIT] = vox_mode_reg;
    end else if (aw_addr_reg == VSM_VOLUME_OFS) begin
      wr_old[3:0] = atten_reg;
    end else if (aw_addr_reg == VSM_TXGAIN_OFS) begin
      wr_old[7:0] = txgain_reg;
    end else if (aw_addr_reg == VSM_VOXLVL_OFS) begin
      wr_old[15:0] = voxlvl_reg;
    end else if (aw_addr_reg == VSM_SQUELCH_OFS) begin
      wr_old[15:0] = squelch_reg;
    end
  end
  assign wr_word = merge(wr_old, w_data_reg, w_strb_reg);

  // Read decode; unmapped reads return zero with an error
  always_comb begin
    rd_data = 32'h0000_0000;
    rd_hit = 1'b1;
    if (AXI_REQ.araddr == VSM_CMD_OFS) begin
      rd_data = {30'h0, mode_reg};
    end else if (AXI_REQ.araddr == VSM_CTRL_OFS) begin
      rd_data[VSM_CTRL_VOX_BIT] = vox_mode_reg;
    end else if (AXI_REQ.araddr == VSM_VOLUME_OFS) begin
      rd_data = {28'h0, atten_reg};
    end else if (AXI_REQ.araddr == VSM_TXGAIN_OFS) begin
      rd_data = {24'h0, txgain_reg};
    end else if (AXI_REQ.araddr == VSM_VOXLVL_OFS) begin
      rd_data = {16'h0, voxlvl_reg};
    end else if (AXI_REQ.araddr == VSM_SQUELCH_OFS) begin
      rd_data = {16'h0, squelch_reg};
    end else if (AXI_REQ.araddr == VSM_STATUS_OFS) begin
      rd_data[1:0] = mode_reg;
      rd_data[VSM_ST_TXKEY_BIT] = TX_KEY;
      rd_data[VSM_ST_SQOPEN_BIT] = sq_open;
      rd_data[VSM_ST_VOXHOLD_BIT] = (vox_cnt_reg != 32'h0);
    end else begin
      rd_hit = 1'b0;
    end
  end

  // Bus handshakes; each ready is offered only while its own channel holds nothing
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      rsp_reg <= '0;
    end else begin
      // Ready drops on the taking edge and returns once the slot is free
      rsp_reg.awready <= (wr_fire || !aw_held_reg) &&
                         !(AXI_REQ.awvalid && rsp_reg.awready);
      rsp_reg.wready <= (wr_fire || !w_held_reg) &&
                        !(AXI_REQ.wvalid && rsp_reg.wready);
      if (wr_fire) begin
        rsp_reg.bvalid <= 1'b1;
        rsp_reg.bresp <= wr_hit ? VSM_RESP_OKAY : VSM_RESP_SLVERR;
      end else if (AXI_REQ.bready) begin
        rsp_reg.bvalid <= 1'b0;
      end
      // Data captured as ready rises; valid only after the handshake
      rsp_reg.arready <= 1'b0;
      if (AXI_REQ.arvalid && rsp_reg.arready) begin
        rsp_reg.rvalid <= 1'b1;
      end else if (AXI_REQ.arvalid && !rsp_reg.rvalid) begin
        rsp_reg.arready <= 1'b1;
        rsp_reg.rdata <= rd_data;
        rsp_reg.rresp <= rd_hit ? VSM_RESP_OKAY : VSM_RESP_SLVERR;
      end else if (rsp_reg.rvalid && AXI_REQ.rready) begin
        rsp_reg.rvalid <= 1'b0;
      end
    end
  end

  // Handshake outputs come straight from flip-flops
  assign AXI_RSP = rsp_reg;

  // Operating mode from host commands
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      mode_reg <= VSM_MODE_DATA;
    end else if (wr_fire && aw_addr_reg == VSM_CMD_OFS && w_strb_reg[0]) begin
      case (w_data_reg[1:0])
        VSM_CMD_DATA: mode_reg <= VSM_MODE_DATA;
        VSM_CMD_VOICE_RX: mode_reg <= VSM_MODE_VOICE_RX;
        VSM_CMD_VOICE_TX: mode_reg <= VSM_MODE_VOICE_TX;
        default: mode_reg <= mode_reg;
      endcase
    end
  end

  // Configuration registers
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      vox_mode_reg <= 1'b0;
      txgain_reg <= VSM_TXGAIN_RST;
      voxlvl_reg <= VSM_VOXLVL_RST;
      squelch_reg <= VSM_SQUELCH_RST;
    end else if (wr_fire) begin
      if (aw_addr_reg == VSM_CTRL_OFS) begin
        vox_mode_reg <= wr_word[VSM_CTRL_VOX_BIT];
      end else if (aw_addr_reg == VSM_TXGAIN_OFS) begin
        txgain_reg <= wr_word[7:0];
      end else if (aw_addr_reg == VSM_VOXLVL_OFS) begin
        voxlvl_reg <= wr_word[15:0];
      end else if (aw_addr_reg == VSM_SQUELCH_OFS) begin
        squelch_reg <= wr_word[15:0];
      end
    end
  end

  // Click detection on entry into a volume state only
  assign lines = {TALK_LINE_A, TALK_LINE_B};
  assign click_up = (lines == 2'b01) && (lines_prev_reg != 2'b01);
  assign click_down = (lines == 2'b10) && (lines_prev_reg != 2'b10);

  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      lines_prev_reg <= 2'b11;
    end else begin
      lines_prev_reg <= lines;
    end
  end

  // Volume held as attenuation; host write beats a click
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      atten_reg <= VSM_VOLUME_RST;
    end else if (wr_fire && aw_addr_reg == VSM_VOLUME_OFS) begin
      atten_reg <= wr_word[3:0];
    end else if (click_up && atten_reg != 4'h0) begin
      atten_reg <= atten_reg - 4'h1;
    end else if (click_down && atten_reg != VSM_VOLUME_MAX) begin
      atten_reg <= atten_reg + 4'h1;
    end
  end

  // Voice trigger: a threshold of zero never keys
  assign mic_abs = mag(MIC_SAMPLE);
  assign vox_trig = vox_mode_reg && (mode_reg != VSM_MODE_DATA) &&
                    (voxlvl_reg != 16'h0) && (mic_abs >= voxlvl_reg);

  // Hold counter restarts on every trigger
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      vox_cnt_reg <= 32'h0;
    end else if (vox_trig) begin
      vox_cnt_reg <= 32'(VOX_HOLD_CYCLES);
    end else if (!vox_mode_reg || mode_reg == VSM_MODE_DATA) begin
      vox_cnt_reg <= 32'h0;
    end else if (vox_cnt_reg != 32'h0) begin
      vox_cnt_reg <= vox_cnt_reg - 32'h1;
    end
  end

  // Keying: command, push-to-talk or voice hold
  always_comb begin
    key_next = 1'b0;
    if (mode_reg == VSM_MODE_VOICE_TX) begin
      key_next = 1'b1;
    end else if (mode_reg == VSM_MODE_VOICE_RX) begin
      if (vox_mode_reg) begin
        key_next = vox_trig || (vox_cnt_reg != 32'h0);
      end else begin
        key_next = (lines == 2'b00);
      end
    end
  end

  // Receive envelope: fast attack, slow decay for the squelch
  assign rx_abs = mag(RX_SAMPLE);
  assign env_next = (rx_abs >= env_reg) ? rx_abs :
                    env_reg - (env_reg >> VSM_ENV_DECAY_SHIFT);

  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      env_reg <= 16'h0;
    end else begin
      env_reg <= env_next;
    end
  end

  assign sq_open = (squelch_reg == 16'h0) ||
                   (env_reg >= squelch_reg);

  // Gain products; both gains are at most unity so no overflow
  assign vol_gain = db_gain(atten_reg);
  assign rx_prod = $signed(RX_SAMPLE) * $signed({1'b0, vol_gain});
  assign mic_prod = $signed(MIC_SAMPLE) * $signed({1'b0, txgain_reg});

  // Audio and indicator outputs, all registered
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      TX_KEY <= 1'b0;
      TX_LED <= 1'b0;
      VOICE_ACTIVE <= 1'b0;
      MOD_SAMPLE <= 16'h0;
      AUDIO_OUT <= 16'h0;
    end else begin
      TX_KEY <= key_next;
      TX_LED <= key_next;
      VOICE_ACTIVE <= (mode_reg != VSM_MODE_DATA);
      MOD_SAMPLE <= key_next ? mic_prod[23:8] : 16'h0;
      // Muted while keyed, so the two paths never overlap
      if (!key_next && mode_reg != VSM_MODE_DATA && sq_open) begin
        AUDIO_OUT <= rx_prod[23:8];
      end else begin
        AUDIO_OUT <= 16'h0;
      end
    end
  end

endmodule
`default_nettype wire

// ===== testbench/vsm_voice_ctrl_properties.sv
`timescale 1ns/100ps
`default_nettype none
module vsm_voice_ctrl_properties #(
  parameter int VOX_HOLD_CYCLES = 50
) (
  input wire logic CLOCK,
  input wire logic RST_B,
  input wire vsm_pkg::vsm_axi_req_s AXI_REQ,
  input wire vsm_pkg::vsm_axi_rsp_s AXI_RSP,
  input wire logic TALK_LINE_A,
  input wire logic TALK_LINE_B,
  input wire logic [15:0] MIC_SAMPLE,
  input wire logic [15:0] RX_SAMPLE,
  input wire logic [15:0] MOD_SAMPLE,
  input wire logic [15:0] AUDIO_OUT,
  input wire logic TX_KEY,
  input wire logic TX_LED,
  input wire logic VOICE_ACTIVE
);
  import vsm_pkg::*;
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_B);
  // Write request and its bounded answer
  sequence s_wr_req;
    AXI_REQ.awvalid && AXI_REQ.wvalid && !AXI_RSP.bvalid;
  endsequence
  sequence s_wr_rsp;
    ##[1:4] AXI_RSP.bvalid;
  endsequence
  AST_LED_IS_KEY: assert property (TX_LED == TX_KEY)
    else $error("indicator differs from key");
  // Key, audio and modulator leave the same flip-flop stage together
  AST_HALF_DUPLEX: assert property (
    TX_KEY |-> AUDIO_OUT == 16'h0)
    else $error("receive audio while keyed");
  AST_MOD_IDLE: assert property (
    !TX_KEY |-> MOD_SAMPLE == 16'h0)
    else $error("modulator fed while unkeyed");
  AST_DATA_QUIET: assert property (
    !VOICE_ACTIVE |-> !TX_KEY && AUDIO_OUT == 16'h0)
    else $error("voice activity in data mode");
  AST_BVALID_STANDS: assert property (
    AXI_RSP.bvalid && !AXI_REQ.bready |=>
      AXI_RSP.bvalid && $stable(AXI_RSP.bresp))
    else $error("write answer dropped");
  AST_RVALID_STANDS: assert property (
    AXI_RSP.rvalid && !AXI_REQ.rready |=>
      AXI_RSP.rvalid && $stable(AXI_RSP.rdata))
    else $error("read answer dropped");
  AST_WRITE_ANSWERED: assert property (s_wr_req |-> s_wr_rsp)
    else $error("write not answered");
  AST_READ_ANSWERED: assert property (
    AXI_REQ.arvalid && !AXI_RSP.rvalid |-> ##[1:3] AXI_RSP.rvalid)
    else $error("read not answered");
endmodule
bind vsm_voice_ctrl vsm_voice_ctrl_properties #(
  .VOX_HOLD_CYCLES(VOX_HOLD_CYCLES)
) chk_u (.CLOCK(CLOCK), .RST_B(RST_B), .AXI_REQ(AXI_REQ), .AXI_RSP(AXI_RSP),
  .TALK_LINE_A(TALK_LINE_A), .TALK_LINE_B(TALK_LINE_B),
  .MIC_SAMPLE(MIC_SAMPLE), .RX_SAMPLE(RX_SAMPLE), .MOD_SAMPLE(MOD_SAMPLE),
  .AUDIO_OUT(AUDIO_OUT), .TX_KEY(TX_KEY), .TX_LED(TX_LED),
  .VOICE_ACTIVE(VOICE_ACTIVE));
`default_nettype wire

// ===== testbench/vsm_headset_model.sv
`timescale 1ns/100ps
`default_nettype none
module vsm_headset_model (
  input wire logic clk,
  input wire logic [1:0] press,
  output logic line_a,
  output logic line_b
);
  // Released buttons sit high; contacts change just after an edge
  initial {line_a, line_b} = 2'h3;
  always @(posedge clk) begin
    {line_a, line_b} <= press;
  end
endmodule
`default_nettype wire

// ===== testbench/vsm_voice_ctrl_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, s) begin checked++; if ((s) !== (e)) begin \
  num_errors++; $display("CHECK FAILED %s exp %0h seen %0h", nm, e, s); \
  end end
module vsm_voice_ctrl_tb_top;
  import vsm_pkg::*;
  localparam int HOLD = 50;
  logic clock = 1'h0, rst_b = 1'h0, line_a, line_b, key, led, vact;
  vsm_axi_req_s req = '0;
  vsm_axi_rsp_s rsp;
  logic [1:0] press = 2'h3, rr;
  logic [15:0] mic = 16'h0, rx = 16'h0, mod_s, aud, a0, m;
  logic [31:0] rd;
  logic [3:0] vol;
  logic [7:0] g;
  bit up;
  int num_errors = 0, checked = 0, cyc = 0;
  logic [7:0] ofs [6] = '{VSM_CMD_OFS, VSM_CTRL_OFS, VSM_VOLUME_OFS,
    VSM_TXGAIN_OFS, VSM_VOXLVL_OFS, VSM_SQUELCH_OFS};
  logic [31:0] rst_v [6] = '{32'h0, 32'h0, 32'(VSM_VOLUME_RST),
    32'(VSM_TXGAIN_RST), 32'(VSM_VOXLVL_RST), 32'(VSM_SQUELCH_RST)};

  vsm_voice_ctrl #(.VOX_HOLD_CYCLES(HOLD)) dut_u (.CLOCK(clock),
    .RST_B(rst_b), .AXI_REQ(req), .AXI_RSP(rsp), .TALK_LINE_A(line_a),
    .TALK_LINE_B(line_b), .MIC_SAMPLE(mic), .RX_SAMPLE(rx),
    .MOD_SAMPLE(mod_s), .AUDIO_OUT(aud), .TX_KEY(key), .TX_LED(led),
    .VOICE_ACTIVE(vact));
  vsm_headset_model head_u (.clk(clock), .press(press), .line_a(line_a),
    .line_b(line_b));

  always #5 clock = ~clock;
  // Hang guard, far above the whole run
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      give_verdict();
    end
  end

  function automatic logic [15:0] exp_mod(logic [15:0] x, logic [7:0] k);
    return 16'((32'(x) * 32'(k)) >> 8);
  endfunction
  // Attenuation steps and saturates at both ends
  function automatic logic [3:0] exp_vol(logic [3:0] v, bit u);
    if (u) return (v == 4'h0) ? v : v - 4'h1;
    return (v == 4'hf) ? v : v + 4'h1;
  endfunction

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask
  // Address and data offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    req <= '{1'h1, a, 1'h1, d, 4'hf, 1'h1, 1'h0, 8'h0, 1'h0};
    do begin
      @(posedge clock);
      if (rsp.awready) req.awvalid <= 1'h0;
      if (rsp.wready) req.wvalid <= 1'h0;
    end while (!rsp.bvalid);
    req.bready <= 1'h0;
    rr = rsp.bresp;
  endtask
  task automatic rd_reg(input logic [7:0] a);
    @(posedge clock);
    req <= '{1'h0, 8'h0, 1'h0, 32'h0, 4'h0, 1'h0, 1'h1, a, 1'h1};
    do begin
      @(posedge clock);
      if (rsp.arready) req.arvalid <= 1'h0;
    end while (!rsp.rvalid);
    req.rready <= 1'h0;
    rd = rsp.rdata;
    rr = rsp.rresp;
  endtask
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    void'($urandom(92));
    tick(12);
    rst_b <= 1'h1;
    foreach (ofs[i]) begin
      rd_reg(ofs[i]);
      `CHK("reset value", rst_v[i], rd)
    end
    rd_reg(8'h1c);
    `CHK("unmapped read", VSM_RESP_SLVERR, rr)
    wr(8'h1c, $urandom());
    `CHK("unmapped write", VSM_RESP_SLVERR, rr)
    $display("test registers done");
    // Clicks held several cycles must step once each
    wr(VSM_CMD_OFS, 32'(VSM_CMD_VOICE_RX));
    tick(2);
    `CHK("voice active", 1'h1, vact)
    wr(VSM_VOLUME_OFS, 32'h1);
    vol = 4'h1;
    for (int i = 0; i < 8; i++) begin
      up = 1'($urandom_range(1, 0));
      press <= up ? 2'h1 : 2'h2;
      tick(3 + $urandom_range(3, 0));
      press <= 2'h3;
      tick(3);
      vol = exp_vol(vol, up);
    end
    rd_reg(VSM_VOLUME_OFS);
    `CHK("volume", 32'(vol), rd)
    $display("test clicks done");
    wr(VSM_VOLUME_OFS, 32'h0);
    rx <= 16'h4000;
    tick(6);
    a0 = aud;
    `CHK("open squelch", 16'h4000, a0)
    wr(VSM_VOLUME_OFS, 32'hf);
    tick(6);
    `CHK("quieter", 1'h1, aud < a0)
    // Envelope must decay below threshold before the mute
    wr(VSM_SQUELCH_OFS, 32'h1000);
    rx <= 16'h0010;
    tick(200);
    `CHK("muted", 16'h0, aud)
    rx <= 16'h2000;
    tick(6);
    `CHK("unmuted", 1'h1, aud != 16'h0)
    wr(VSM_SQUELCH_OFS, 32'h0);
    $display("test receive done");
    for (int i = 0; i < 3; i++) begin
      g = 8'($urandom_range(255, 1));
      m = 16'($urandom_range(32767, 0));
      wr(VSM_TXGAIN_OFS, 32'(g));
      mic <= m;
      press <= 2'h0;
      tick(4);
      `CHK("ptt key", 1'h1, key)
      `CHK("mic path", exp_mod(m, g), mod_s)
      `CHK("rx muted", 16'h0, aud)
      press <= 2'h3;
      tick(4);
      `CHK("ptt unkey", 1'h0, key)
    end
    $display("test push to talk done");
    // Voice keying: background and pressed lines must not key
    wr(VSM_CTRL_OFS, 32'h1);
    wr(VSM_VOXLVL_OFS, 32'h1000);
    mic <= 16'h0400;
    press <= 2'h0;
    tick(100);
    `CHK("vox quiet", 1'h0, key)
    press <= 2'h3;
    mic <= 16'h2000;
    tick(1);
    mic <= 16'h0;
    tick(HOLD - 5);
    `CHK("vox hold", 1'h1, key)
    tick(45);
    `CHK("vox release", 1'h0, key)
    wr(VSM_CTRL_OFS, 32'h0);
    $display("test voice keying done");
    wr(VSM_CMD_OFS, 32'(VSM_CMD_VOICE_TX));
    tick(2);
    `CHK("cmd key", 1'h1, key)
    `CHK("cmd led", 1'h1, led)
    rd_reg(VSM_STATUS_OFS);
    `CHK("tx mode", 2'h2, rd[1:0])
    wr(VSM_CMD_OFS, 32'(VSM_CMD_DATA));
    tick(2);
    `CHK("data mode", 2'h0, {vact, key})
    $display("test commands done");
    give_verdict();
  end
endmodule
`default_nettype wire
